// [core/vstm_pkg.sv]
// Shared constants and types for the video source and trigger mux
// How it works
// - Configuration picks DVI receiver or video processor as video source.
// - DVI pixels pass to the display controller unchanged.
// - Two 16-bit processor words merge into one RGB888 pixel: all of the first word plus the second word's upper byte.
// - Output toward the display controller is a 24-bit RGB888 bus.
// - Takes buffer index, swap, shown pulse, strobes; drives invert and syncs.
// - Trigger sources are software pulse, auto timer and external input.
// - Auto trigger rate is programmable from 1 Hz to 4000 Hz.
// - External trigger polarity, delay and accepted pulse width are set.
// - Stored pattern mode takes only auto or external trigger.
// - Camera trigger output has set polarity, delay and pulse width.
// - In stored mode LED strobes have set delay and on time, locked to trigger; otherwise they pass through.
// - In stored mode a buffer swap request makes two blank lines then a frame sync.
// - All functions are set through registers written by a host.
// - Camera trigger is derived from the controller's pattern-shown pulse.
package vstm_pkg;

  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned AUTO_MIN_HZ = 1;
  localparam int unsigned AUTO_MAX_HZ = 4000;
  localparam int unsigned AUTO_FAST_CYC = CLK_HZ / AUTO_MAX_HZ;
  localparam int unsigned AUTO_SLOW_CYC = CLK_HZ / AUTO_MIN_HZ;

  localparam int unsigned LINE_LEN    = 800;
  localparam int unsigned HS_WIDTH    = 16;
  localparam int unsigned VS_WIDTH    = 16;
  localparam int unsigned DUMMY_LINES = 2;

  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_PERIOD    = 8'h04;
  localparam logic [7:0] ADDR_EXT_DELAY = 8'h08;
  localparam logic [7:0] ADDR_EXT_WIDTH = 8'h0C;
  localparam logic [7:0] ADDR_CAM_DELAY = 8'h10;
  localparam logic [7:0] ADDR_CAM_WIDTH = 8'h14;
  localparam logic [7:0] ADDR_LED_DELAY = 8'h18;
  localparam logic [7:0] ADDR_LED_WIDTH = 8'h1C;
  localparam logic [7:0] ADDR_STATUS    = 8'h20;

  localparam int CTRL_VSRC   = 0;
  localparam int CTRL_TSRC   = 1;
  localparam int CTRL_EXTPOL = 3;
  localparam int CTRL_CAMPOL = 4;
  localparam int CTRL_STORED = 5;
  localparam int CTRL_INVEN  = 6;
  localparam int CTRL_SWTRIG = 7;
  localparam int CTRL_LEDSEL = 8;

  localparam int STAT_RDBUF  = 0;
  localparam int STAT_BUSY   = 2;
  localparam int STAT_INV    = 3;
  localparam int STAT_SWAPS  = 8;

  localparam logic [31:0] WIDTH_RST = 32'h0000_0001;
  localparam logic [31:0] DELAY_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    TRIG_SW   = 2'b00,
    TRIG_AUTO = 2'b01,
    TRIG_EXT  = 2'b10
  } vstm_trig_t;

  typedef enum logic [1:0] {
    PG_IDLE   = 2'b00,
    PG_DELAY  = 2'b01,
    PG_ACTIVE = 2'b11
  } vstm_pg_t;

  typedef enum logic [1:0] {
    DF_IDLE  = 2'b00,
    DF_LINE  = 2'b01,
    DF_VSYNC = 2'b11
  } vstm_df_t;

  typedef struct packed {
    logic [23:0] data;
    logic        hsync;
    logic        vsync;
    logic        pixel_valid_enable;
  } vstm_vid_t;

  typedef struct packed {
    logic [2:0] led_sel;
    logic       invert_en;
    logic       stored_mode;
    logic       cam_pol;
    logic       ext_pol;
    vstm_trig_t trig_src;
    logic       video_src;
  } vstm_cfg_t;

endpackage : vstm_pkg

// [core/vstm_pulse.sv]
// Delayed pulse generator: start, wait a delay, hold high for a width
`timescale 1ns/100ps
module vstm_pulse
  import vstm_pkg::*;
#(
  parameter int CW = 32
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          start,
  input  wire logic [CW-1:0] delay,
  input  wire logic [CW-1:0] width,
  output logic               pulse,
  output logic               busy
);

  vstm_pg_t      state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] width_m1;

  assign width_m1 = (width == '0) ? '0 : width - 1'b1;
  assign busy     = (state != PG_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PG_IDLE;
      cnt   <= '0;
      pulse <= 1'b0;
    end else begin
      case (state)
        PG_IDLE: begin
          if (start && delay == '0) begin
            state <= PG_ACTIVE;
            cnt   <= width_m1;
            pulse <= 1'b1;
          end else if (start) begin
            state <= PG_DELAY;
            cnt   <= delay - 1'b1;
          end
        end
        PG_DELAY: begin
          if (cnt == '0) begin
            state <= PG_ACTIVE;
            cnt   <= width_m1;
            pulse <= 1'b1;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        PG_ACTIVE: begin
          if (cnt == '0) begin
            state <= PG_IDLE;
            pulse <= 1'b0;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: begin
          state <= PG_IDLE;
          pulse <= 1'b0;
        end
      endcase
    end
  end

  chk_pulse_prompt: assert property (@(posedge pclk) disable iff (!presetn)
    (state == PG_IDLE && start && delay == '0) |=> pulse)
    else $error("pulse did not start at zero delay");

  chk_pulse_end: assert property (@(posedge pclk) disable iff (!presetn)
    (state == PG_ACTIVE && cnt == '0) |=> !pulse && state == PG_IDLE)
    else $error("pulse outlived its width");

  chk_pulse_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (state == PG_IDLE && start && delay == 2) |=>
      !pulse ##1 !pulse ##1 pulse)
    else $error("pulse delay miscounted");

endmodule : vstm_pulse

// [core/vstm_top.sv]
// Video source and trigger mux with APB register access
`timescale 1ns/100ps
module vstm_top
  import vstm_pkg::*;
#(
  parameter int unsigned AUTO_FAST = AUTO_FAST_CYC,
  parameter int unsigned AUTO_SLOW = AUTO_SLOW_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire vstm_vid_t   dvi_in,
  input  wire logic [15:0] vp_word,
  input  wire logic        vp_word_valid,
  input  wire logic        vp_hsync,
  input  wire logic        vp_vsync,
  input  wire logic [1:0]  rd_buf,
  input  wire logic        buffer_swap,
  input  wire logic        pattern_shown,
  input  wire logic [2:0]  led_strobe_in,
  input  wire logic        ext_trig_in,
  output vstm_vid_t        vid_out,
  output logic             pattern_invert,
  output logic             pattern_trigger,
  output logic             cam_trig_out,
  output logic [2:0]       led_strobe_out
);

  vstm_cfg_t   cfg;
  logic [31:0] period;
  logic [31:0] ext_delay;
  logic [31:0] ext_width;
  logic [31:0] cam_delay;
  logic [31:0] cam_width;
  logic [31:0] led_delay;
  logic [31:0] led_width;
  logic        sw_pulse;
  logic [7:0]  swap_count;
  logic [31:0] status;
  logic        df_busy;

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        pslverr <= 1'b0;
        case (paddr)
          ADDR_CTRL:      prdata <= {21'h00_0000, cfg.led_sel, 1'b0, cfg[6:0]};
          ADDR_PERIOD:    prdata <= period;
          ADDR_EXT_DELAY: prdata <= ext_delay;
          ADDR_EXT_WIDTH: prdata <= ext_width;
          ADDR_CAM_DELAY: prdata <= cam_delay;
          ADDR_CAM_WIDTH: prdata <= cam_width;
          ADDR_LED_DELAY: prdata <= led_delay;
          ADDR_LED_WIDTH: prdata <= led_width;
          ADDR_STATUS:    prdata <= status;
          default: begin
            prdata  <= '0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  assign status = {16'h0000, swap_count, 4'h0, pattern_invert, df_busy,
                   rd_buf};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg       <= '0;
      period    <= AUTO_FAST;
      ext_delay <= DELAY_RST;
      ext_width <= WIDTH_RST;
      cam_delay <= DELAY_RST;
      cam_width <= WIDTH_RST;
      led_delay <= DELAY_RST;
      led_width <= WIDTH_RST;
      sw_pulse  <= 1'b0;
    end else begin
      sw_pulse <= 1'b0;
      if (psel && penable && pwrite) begin
        case (paddr)
          ADDR_CTRL: begin
            cfg.video_src   <= pwdata[CTRL_VSRC];
            cfg.trig_src    <= vstm_trig_t'(pwdata[CTRL_TSRC +: 2]);
            cfg.ext_pol     <= pwdata[CTRL_EXTPOL];
            cfg.cam_pol     <= pwdata[CTRL_CAMPOL];
            cfg.stored_mode <= pwdata[CTRL_STORED];
            cfg.invert_en   <= pwdata[CTRL_INVEN];
            cfg.led_sel     <= pwdata[CTRL_LEDSEL +: 3];
            sw_pulse        <= pwdata[CTRL_SWTRIG];
          end
          ADDR_PERIOD:    period    <= pwdata;
          ADDR_EXT_DELAY: ext_delay <= pwdata;
          ADDR_EXT_WIDTH: ext_width <= pwdata;
          ADDR_CAM_DELAY: cam_delay <= pwdata;
          ADDR_CAM_WIDTH: cam_width <= pwdata;
          ADDR_LED_DELAY: led_delay <= pwdata;
          ADDR_LED_WIDTH: led_width <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Auto trigger timer
  // ------------------------------------------------------------
  logic [31:0] period_c;
  logic [31:0] auto_cnt;
  logic        auto_pulse;

  always_comb begin
    if (period < AUTO_FAST)
      period_c = AUTO_FAST;
    else if (period > AUTO_SLOW)
      period_c = AUTO_SLOW;
    else
      period_c = period;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_cnt   <= '0;
      auto_pulse <= 1'b0;
    end else if (cfg.trig_src != TRIG_AUTO) begin
      auto_cnt   <= '0;
      auto_pulse <= 1'b0;
    end else if (auto_cnt >= period_c - 1) begin
      auto_cnt   <= '0;
      auto_pulse <= 1'b1;
    end else begin
      auto_cnt   <= auto_cnt + 1'b1;
      auto_pulse <= 1'b0;
    end
  end

  chk_auto_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    auto_pulse |=> !auto_pulse [*8])
    else $error("auto trigger pulses too close");

  // ------------------------------------------------------------
  // External trigger conditioning
  // ------------------------------------------------------------
  logic        ext_level;
  logic [31:0] ext_cnt;
  logic [31:0] ext_need;
  logic        ext_accept;
  logic        ext_fire;

  assign ext_level = ext_trig_in ^ cfg.ext_pol;
  assign ext_need  = (ext_width == '0) ? 32'h0000_0001 : ext_width;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_cnt    <= '0;
      ext_accept <= 1'b0;
    end else begin
      ext_accept <= ext_level && (ext_cnt == ext_need - 1);
      if (!ext_level)
        ext_cnt <= '0;
      else if (ext_cnt < ext_need)
        ext_cnt <= ext_cnt + 1'b1;
    end
  end

  vstm_pulse #(.CW(32)) u_ext_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (ext_accept),
    .delay   (ext_delay),
    .width   (WIDTH_RST),
    .pulse   (ext_fire),
    .busy    ()
  );

  chk_ext_filter: assert property (@(posedge pclk) disable iff (!presetn)
    ext_accept |-> $past(ext_level) && !$past(ext_accept))
    else $error("external trigger accepted without active level");

  // ------------------------------------------------------------
  // Trigger selection
  // ------------------------------------------------------------
  logic trig_raw;

  always_comb begin
    case (cfg.trig_src)
      TRIG_SW:   trig_raw = sw_pulse && !cfg.stored_mode;
      TRIG_AUTO: trig_raw = auto_pulse;
      TRIG_EXT:  trig_raw = ext_fire;
      default:   trig_raw = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pattern_trigger <= 1'b0;
    else
      pattern_trigger <= trig_raw;
  end

  chk_sw_stored: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.stored_mode && cfg.trig_src == TRIG_SW) |=> !pattern_trigger)
    else $error("software trigger passed in stored mode");

  // ------------------------------------------------------------
  // Camera trigger and LED strobes
  // ------------------------------------------------------------
  logic cam_pulse;
  logic led_pulse;

  vstm_pulse #(.CW(32)) u_cam (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (pattern_shown),
    .delay   (cam_delay),
    .width   (cam_width),
    .pulse   (cam_pulse),
    .busy    ()
  );

  vstm_pulse #(.CW(32)) u_led (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (pattern_trigger),
    .delay   (led_delay),
    .width   (led_width),
    .pulse   (led_pulse),
    .busy    ()
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cam_trig_out   <= 1'b0;
      led_strobe_out <= '0;
    end else begin
      cam_trig_out <= cam_pulse ^ cfg.cam_pol;
      if (cfg.stored_mode)
        led_strobe_out <= led_pulse ? cfg.led_sel : 3'h0;
      else
        led_strobe_out <= led_strobe_in;
    end
  end

  chk_cam_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !cam_pulse |=> cam_trig_out == $past(cfg.cam_pol))
    else $error("camera trigger polarity wrong while idle");

  // ------------------------------------------------------------
  // Buffer rotation dummy frame
  // ------------------------------------------------------------
  vstm_df_t   df_state;
  logic [9:0] df_pix;
  logic       df_line;

  assign df_busy = (df_state != DF_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      df_state   <= DF_IDLE;
      df_pix     <= '0;
      df_line    <= 1'b0;
      swap_count <= '0;
    end else begin
      case (df_state)
        DF_IDLE: begin
          if (buffer_swap && cfg.stored_mode) begin
            df_state   <= DF_LINE;
            df_pix     <= '0;
            df_line    <= 1'b0;
            swap_count <= swap_count + 1'b1;
          end
        end
        DF_LINE: begin
          if (df_pix == 10'(LINE_LEN - 1)) begin
            df_pix <= '0;
            if (df_line == 1'(DUMMY_LINES - 1))
              df_state <= DF_VSYNC;
            else
              df_line <= 1'b1;
          end else begin
            df_pix <= df_pix + 1'b1;
          end
        end
        DF_VSYNC: begin
          if (df_pix == 10'(VS_WIDTH - 1)) begin
            df_state <= DF_IDLE;
            df_pix   <= '0;
          end else begin
            df_pix <= df_pix + 1'b1;
          end
        end
        default: df_state <= DF_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Video processor word merge
  // ------------------------------------------------------------
  logic        vp_phase;
  logic [15:0] vp_hi;
  logic [23:0] vp_pix;
  logic        vp_pix_valid;
  logic        vp_hs_d;
  logic        vp_vs_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vp_phase     <= 1'b0;
      vp_hi        <= '0;
      vp_pix       <= '0;
      vp_pix_valid <= 1'b0;
      vp_hs_d      <= 1'b0;
      vp_vs_d      <= 1'b0;
    end else begin
      vp_hs_d      <= vp_hsync;
      vp_vs_d      <= vp_vsync;
      vp_pix_valid <= 1'b0;
      if (vp_hsync) begin
        vp_phase <= 1'b0;
      end else if (vp_word_valid && !vp_phase) begin
        vp_hi    <= vp_word;
        vp_phase <= 1'b1;
      end else if (vp_word_valid) begin
        vp_pix       <= {vp_hi, vp_word[15:8]};
        vp_pix_valid <= 1'b1;
        vp_phase     <= 1'b0;
      end
    end
  end

  chk_vp_merge: assert property (@(posedge pclk) disable iff (!presetn)
    (vp_word_valid && vp_phase && !vp_hsync) |=>
      vp_pix_valid && vp_pix == {$past(vp_hi), $past(vp_word[15:8])})
    else $error("processor word pair merged wrongly");

  // ------------------------------------------------------------
  // Output toward the display controller
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vid_out <= '0;
    end else if (cfg.stored_mode) begin
      vid_out.data               <= '0;
      vid_out.pixel_valid_enable <= 1'b0;
      vid_out.hsync <= (df_state == DF_LINE) && (df_pix < 10'(HS_WIDTH));
      vid_out.vsync <= (df_state == DF_VSYNC);
    end else if (!cfg.video_src) begin
      vid_out <= dvi_in;
    end else begin
      vid_out.data               <= vp_pix;
      vid_out.pixel_valid_enable <= vp_pix_valid;
      vid_out.hsync              <= vp_hs_d;
      vid_out.vsync              <= vp_vs_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pattern_invert <= 1'b0;
    else if (!cfg.invert_en)
      pattern_invert <= 1'b0;
    else if (pattern_shown)
      pattern_invert <= !pattern_invert;
  end

  chk_dvi_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (!cfg.stored_mode && !cfg.video_src) |=> vid_out == $past(dvi_in))
    else $error("DVI data altered on its way out");

  chk_swap_frame: assert property (@(posedge pclk) disable iff (!presetn)
    (df_state == DF_IDLE && buffer_swap && cfg.stored_mode)
      ##1 cfg.stored_mode [*2] |-> vid_out.hsync)
    else $error("swap did not start a blank line");

  chk_blank_data: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.stored_mode |=> !vid_out.pixel_valid_enable)
    else $error("data enable high during dummy frame");

  chk_invert_flip: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.invert_en && pattern_shown) |=>
      (!cfg.invert_en || pattern_invert != $past(pattern_invert)))
    else $error("pattern invert did not toggle");

endmodule : vstm_top

// [bench/vstm_disp_model.sv]
// Behavioural display controller on the far side of the video mux
`timescale 1ns/100ps
module vstm_disp_model
  import vstm_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire vstm_vid_t  vid_out,
  input  wire logic       shown_req,
  input  wire logic       swap_req,
  input  wire logic [2:0] strobe_req,
  output logic [1:0]      rd_buf,
  output logic            buffer_swap,
  output logic            pattern_shown,
  output logic [2:0]      led_strobe_in
);
  logic vs_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern_shown <= 1'b0;
      buffer_swap   <= 1'b0;
      led_strobe_in <= 3'h0;
    end else begin
      pattern_shown <= shown_req;
      buffer_swap   <= swap_req;
      led_strobe_in <= strobe_req;
    end
  end

  // Active buffer advances once the frame sync ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vs_d   <= 1'b0;
      rd_buf <= 2'h0;
    end else begin
      vs_d <= vid_out.vsync;
      if (vs_d && !vid_out.vsync) begin
        rd_buf <= rd_buf + 2'h1;
      end
    end
  end
endmodule : vstm_disp_model

// [bench/tb_video_source_and_trigger_mux.sv]
// Self-checking bench for the video source and trigger mux
`timescale 1ns/100ps
module tb_video_source_and_trigger_mux
  import vstm_pkg::*;
;
  localparam int unsigned P_FAST = 20;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, d;
  logic        pready, pslverr, err;
  vstm_vid_t   dvi_in = '0, vid_out, dvi_prev = '0;
  logic [15:0] vp_word = 16'h0000, w1;
  logic        vp_word_valid = 0, vp_hsync = 0, ext_trig_in = 1;
  logic        shown_req = 0, swap_req = 0, ph = 0, hp;
  logic [2:0]  strobe_req = 3'h0, led_strobe_in, led_strobe_out;
  logic [1:0]  rd_buf;
  logic        buffer_swap, pattern_shown, pattern_invert;
  logic        pattern_trigger, cam_trig_out;
  logic [23:0] vq[$];
  int          num_errors = 0, cmp_count = 0, cyc_cnt = 0, chk_mode = 0;
  int          c, g, hr, hh, vh, bad;

  always #5 pclk = ~pclk;

  vstm_top #(.AUTO_FAST(P_FAST), .AUTO_SLOW(200)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dvi_in(dvi_in),
    .vp_word(vp_word), .vp_word_valid(vp_word_valid),
    .vp_hsync(vp_hsync), .vp_vsync(1'b0), .rd_buf(rd_buf),
    .buffer_swap(buffer_swap), .pattern_shown(pattern_shown),
    .led_strobe_in(led_strobe_in), .ext_trig_in(ext_trig_in),
    .vid_out(vid_out), .pattern_invert(pattern_invert),
    .pattern_trigger(pattern_trigger), .cam_trig_out(cam_trig_out),
    .led_strobe_out(led_strobe_out));

  vstm_disp_model partner (
    .pclk(pclk), .presetn(presetn), .vid_out(vid_out),
    .shown_req(shown_req), .swap_req(swap_req), .strobe_req(strobe_req),
    .rd_buf(rd_buf), .buffer_swap(buffer_swap),
    .pattern_shown(pattern_shown), .led_strobe_in(led_strobe_in));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task tally_and_finish();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task chk(string nm, logic [31:0] e, logic [31:0] v);
    cmp_count++;
    if (v !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, v);
    end
  endtask : chk

  task apb(logic wr, logic [7:0] a, logic [31:0] wd);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask : apb

  task count_trig(int n, int rel);
    c = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      if (i == rel) ext_trig_in <= 1'b1;
      if (pattern_trigger === 1'b1) c++;
    end
  endtask : count_trig

  task gap();
    do @(posedge pclk); while (pattern_trigger !== 1'b1);
    g = 0;
    do begin @(posedge pclk); g++; end
    while (pattern_trigger !== 1'b1 && g < 1000);
  endtask : gap

  // Reference model of both video paths
  always @(posedge pclk) begin
    if (chk_mode == 1) chk("dvi", {5'h00, dvi_prev}, {5'h00, vid_out});
    if (chk_mode == 2 && vid_out.pixel_valid_enable === 1'b1) begin
      if (vq.size() == 0) chk("vp_extra", 32'h0000_0000, 32'h0000_0001);
      else chk("vp_pix", {8'h00, vq.pop_front()}, {8'h00, vid_out.data});
    end
    if (vp_hsync) ph = 0;
    else if (vp_word_valid) begin
      if (ph) vq.push_back({w1, vp_word[15:8]});
      else w1 = vp_word;
      ph = !ph;
    end
    dvi_prev = dvi_in;
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(14));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, ADDR_CTRL, 0); chk("ctrl_rst", 0, d);
    apb(0, ADDR_PERIOD, 0); chk("period_rst", P_FAST, d);
    apb(0, ADDR_CAM_WIDTH, 0); chk("width_rst", WIDTH_RST, d);
    apb(0, 8'h24, 0); chk("unmapped", 32'h0000_0001, {31'h0, err});
    chk_mode = 1;
    repeat (60) begin
      @(posedge pclk);
      dvi_in <= vstm_vid_t'(27'($urandom));
    end
    chk_mode = 0;
    apb(1, ADDR_CTRL, 32'h0000_0001);
    vp_hsync <= 1; @(posedge pclk); vp_hsync <= 0;
    repeat (3) @(posedge pclk);
    chk_mode = 2;
    repeat (8) begin
      vp_word <= 16'($urandom); vp_word_valid <= 1; @(posedge pclk);
    end
    vp_word_valid <= 0;
    repeat (6) @(posedge pclk);
    chk("vp_left", 0, vq.size());
    chk_mode = 0;
    apb(1, ADDR_CTRL, 32'h0000_0080); count_trig(10, -1);
    chk("sw_trig", 1, c);
    apb(1, ADDR_PERIOD, 32'h0000_0005); apb(1, ADDR_CTRL, 32'h0000_0002);
    gap(); gap(); chk("auto_min", P_FAST, g);
    apb(1, ADDR_PERIOD, 32'h0000_0032);
    gap(); gap(); chk("auto_50", 50, g);
    apb(1, ADDR_EXT_WIDTH, 32'h0000_0003); apb(1, ADDR_EXT_DELAY, 32'h0000_0004);
    apb(1, ADDR_CTRL, 32'h0000_000C);
    ext_trig_in <= 0; count_trig(40, 0);
    chk("ext_short", 0, c);
    ext_trig_in <= 0; count_trig(40, 6);
    chk("ext_long", 1, c);
    apb(1, ADDR_CAM_WIDTH, 32'h0000_0005); apb(1, ADDR_CAM_DELAY, 32'h0000_0003);
    apb(1, ADDR_CTRL, 32'h0000_0050);
    @(posedge pclk);
    chk("cam_idle", 1, cam_trig_out);
    shown_req <= 1; @(posedge pclk); shown_req <= 0;
    g = 0; while (cam_trig_out !== 1'b0 && g < 100) begin @(posedge pclk); g++; end
    c = 0; while (cam_trig_out === 1'b0 && c < 100) begin @(posedge pclk); c++; end
    chk("cam_width", 5, c);
    apb(0, ADDR_STATUS, 0); chk("invert", 1, d[STAT_INV]);
    chk("invert_pin", 1, pattern_invert);
    apb(1, ADDR_LED_DELAY, 32'h0000_0002); apb(1, ADDR_LED_WIDTH, 32'h0000_0003);
    apb(1, ADDR_CTRL, 32'h0000_0522);
    g = 0; while (led_strobe_out !== 3'h5 && g < 200) begin @(posedge pclk); g++; end
    chk("led_sel", 3'h5, led_strobe_out);
    apb(1, ADDR_CTRL, 32'h0000_05A0); count_trig(10, -1);
    chk("stored_sw", 0, c);
    apb(0, ADDR_CTRL, 0); chk("ctrl_rd", 32'h0000_0520, d);
    swap_req <= 1; @(posedge pclk); swap_req <= 0;
    hr = 0; hh = 0; vh = 0; bad = 0; hp = 0;
    for (int i = 0; i < 2000; i++) begin
      @(posedge pclk);
      if (vid_out.hsync === 1'b1) begin hh++; if (!hp) hr++; end
      hp = vid_out.hsync;
      if (vid_out.vsync === 1'b1) vh++;
      if (vid_out.pixel_valid_enable !== 1'b0) bad++;
      if (vh > 0 && vid_out.vsync === 1'b0) break;
    end
    chk("dummy_lines", DUMMY_LINES, hr);
    chk("hs_cycles", DUMMY_LINES * HS_WIDTH, hh);
    chk("vs_cycles", VS_WIDTH, vh);
    chk("dummy_pve", 0, bad);
    repeat (3) @(posedge pclk);
    apb(0, ADDR_STATUS, 0); chk("status", 32'h0000_0101, d & 32'h0000_FF03);
    apb(1, ADDR_CTRL, 0); strobe_req <= 3'h6;
    repeat (4) @(posedge pclk);
    chk("led_pass", 3'h6, led_strobe_out);
    tally_and_finish();
  end
endmodule : tb_video_source_and_trigger_mux
